//--- logic/wot_map.svh
// wot_map.svh: widths, reset values and encodings of the wait one-shot timer
// assumes: included by its bare name from the design modules
`ifndef WOT_MAP_SVH
`define WOT_MAP_SVH

// ----------------------------------------------------------------------------
// widths and reset values
// ----------------------------------------------------------------------------
`define WOT_CNT_W        8
`define WOT_PRE_RESET    8'hFF
`define WOT_PRI_RESET    8'hFF
`define WOT_SEC_RESET    8'hFF

// ----------------------------------------------------------------------------
// count source select encodings
// ----------------------------------------------------------------------------
`define WOT_SRC_DIV1     2'h0
`define WOT_SRC_DIV2     2'h1
`define WOT_SRC_DIV8     2'h2
`define WOT_SRC_UFLOW    2'h3
`define WOT_DIV8_LAST    3'h7

`endif

//--- logic/wot_pkg.sv
// wot_pkg.sv: types of the wait one-shot timer
// assumes: compiled before the design modules
package wot_pkg;

  // ----------------------------------------------------------------------------
  // sequence states
  // ----------------------------------------------------------------------------
  typedef enum logic [1:0] {
    WOT_IDLE,
    WOT_WAIT,
    WOT_PULSE
  } wot_state_t;

  typedef logic [1:0] wot_src_t;

endpackage : wot_pkg

//--- logic/wot_tick_gen.sv
// wot_tick_gen.sv: count-source tick generator, one pulse per count-source period
// assumes: companion underflow is a one-cycle pulse on clk_i
`timescale 1ns/1ns
`include "wot_map.svh"

module wot_tick_gen (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire wot_pkg::wot_src_t src_sel_i,
  input  wire logic              companion_uflow_i,
  output logic                   tick_o
);

  logic [2:0] div_reg;

  // ----------------------------------------------------------------------------
  // free-running divider
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_reg <= 3'h0;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end

  always_comb begin
    case (src_sel_i)
      `WOT_SRC_DIV1:  tick_o = 1'b1;
      `WOT_SRC_DIV2:  tick_o = div_reg[0];
      `WOT_SRC_DIV8:  tick_o = (div_reg == `WOT_DIV8_LAST);
      default:        tick_o = companion_uflow_i;
    endcase
  end

endmodule : wot_tick_gen

//--- logic/wot_timer.sv
// wot_timer.sv: programmable wait one-shot pulse timer, top level
// assumes: control bits are plain ports; strobes are one-cycle pulses on clk_i;
// external trigger pin is asynchronous
//
// Behaviour
// - count source is clk/1, clk/2, clk/8 or companion timer underflow
// - primary underflow loads secondary period and counting continues
// - secondary underflow reloads primary, ends one-shot, clears status flag
// - wait lasts (prescale+1)*(primary+1) count-source periods
// - pulse lasts (prescale+1)*(secondary+1) count-source periods to secondary underflow, then ends with the interrupt
// - with count enable set, the next trigger starts a one-shot
// - writing one-shot start bit starts a one-shot from software
// - external pin edge starts a one-shot when external trigger selected
// - counting stops once reload after secondary underflow completes
// - writing one-shot stop bit stops the one-shot
// - clearing count enable stops counting
// - writing forced stop bit stops counting at once
// - interrupt half a count-source cycle after secondary underflow (next clock for clk/1, next tick for companion underflow), with pulse end
// - count reads come from primary counter and prescaler counter
// - software writes prescale, secondary and primary period values
// - output level select sets the active level of the pulse
`timescale 1ns/1ns
`include "wot_map.svh"

module wot_timer #(
  parameter int W = `WOT_CNT_W
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire wot_pkg::wot_src_t src_sel_i,
  input  wire logic              companion_uflow_i,
  input  wire logic              count_enable_bit_i,
  input  wire logic              forced_stop_bit_i,
  input  wire logic              oneshot_start_bit_i,
  input  wire logic              oneshot_stop_bit_i,
  input  wire logic              output_level_select_i,
  input  wire logic              ext_trig_select_i,
  input  wire logic              ext_trig_falling_i,
  input  wire logic              external_trigger_pin_i,
  input  wire logic              prescale_wr_i,
  input  wire logic              primary_wr_i,
  input  wire logic              secondary_wr_i,
  input  wire logic [W-1:0]      wr_data_i,
  output logic [W-1:0]           prescale_count_o,
  output logic [W-1:0]           primary_count_o,
  output logic [W-1:0]           prescale_reg_o,
  output logic [W-1:0]           primary_period_reg_o,
  output logic [W-1:0]           secondary_period_reg_o,
  output logic                   count_enable_o,
  output logic                   oneshot_status_flag_o,
  output logic                   pulse_output_pin_o,
  output logic                   irq_o
);

  // ----------------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------------
  wot_pkg::wot_state_t state_reg;
  logic [W-1:0]        prescale_reg;
  logic [W-1:0]        primary_period_reg;
  logic [W-1:0]        secondary_period_reg;
  logic [W-1:0]        pre_cnt_reg;
  logic [W-1:0]        main_cnt_reg;
  logic                count_enable_reg;
  logic                end_pending_reg;
  logic [1:0]          half_cnt_reg;
  logic                pulse_reg;
  logic                pulse_next;
  logic                pin_reg;
  logic                end_now;
  logic                irq_reg;
  logic                tick;
  logic                ext_edge;
  logic                trigger;
  logic                abort;
  logic                pre_uflow;
  logic                main_uflow;

  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  wot_tick_gen u_tick (
    .clk_i             (clk_i),
    .rst_n_i           (rst_n_i),
    .src_sel_i         (src_sel_i),
    .companion_uflow_i (companion_uflow_i),
    .tick_o            (tick)
  );

  wot_trig_sync u_trig (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (external_trigger_pin_i),
    .falling_i (ext_trig_falling_i),
    .edge_o    (ext_edge)
  );

  function automatic logic is_zero(input logic [W-1:0] v);
    is_zero = (v == '0);
  endfunction : is_zero

  // true on the edge half a count-source period after the secondary underflow, or on the next tick for companion underflow;
  // the undivided clock has no half period, so its pulse ends at the next edge
  function automatic logic half_reached(input wot_pkg::wot_src_t src,
                                        input logic [1:0]        half,
                                        input logic              tk);
    case (src)
      `WOT_SRC_DIV1: half_reached = 1'b1;
      `WOT_SRC_DIV2: half_reached = 1'b1;
      `WOT_SRC_DIV8: half_reached = (half == 2'h3);
      default:       half_reached = tk;
    endcase
  endfunction : half_reached

  // ----------------------------------------------------------------------------
  // start, stop and underflow conditions
  // ----------------------------------------------------------------------------
  assign trigger    = count_enable_reg & ~forced_stop_bit_i &
                      (oneshot_start_bit_i | (ext_trig_select_i & ext_edge));
  assign abort      = oneshot_stop_bit_i | ~count_enable_reg | forced_stop_bit_i;
  assign pre_uflow  = tick & is_zero(pre_cnt_reg);
  assign main_uflow = pre_uflow & is_zero(main_cnt_reg);
  assign end_now    = end_pending_reg & half_reached(src_sel_i, half_cnt_reg, tick);

  // ----------------------------------------------------------------------------
  // count enable: forced stop also clears it
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_enable_reg <= 1'b0;
    end else if (forced_stop_bit_i) begin
      count_enable_reg <= 1'b0;
    end else begin
      count_enable_reg <= count_enable_bit_i;
    end
  end

  // ----------------------------------------------------------------------------
  // period registers
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prescale_reg         <= `WOT_PRE_RESET;
      primary_period_reg   <= `WOT_PRI_RESET;
      secondary_period_reg <= `WOT_SEC_RESET;
    end else begin
      if (prescale_wr_i) begin
        prescale_reg <= wr_data_i;
      end
      if (primary_wr_i) begin
        primary_period_reg <= wr_data_i;
      end
      if (secondary_wr_i) begin
        secondary_period_reg <= wr_data_i;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // sequence state
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= wot_pkg::WOT_IDLE;
    end else begin
      case (state_reg)
        wot_pkg::WOT_IDLE: begin
          if (trigger) begin
            state_reg <= wot_pkg::WOT_WAIT;
          end
        end
        wot_pkg::WOT_WAIT: begin
          if (abort) begin
            state_reg <= wot_pkg::WOT_IDLE;
          end else if (main_uflow) begin
            state_reg <= wot_pkg::WOT_PULSE;
          end
        end
        wot_pkg::WOT_PULSE: begin
          if (abort || main_uflow) begin
            state_reg <= wot_pkg::WOT_IDLE;
          end
        end
        default: state_reg <= wot_pkg::WOT_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // prescaler and main counter
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_cnt_reg  <= `WOT_PRE_RESET;
      main_cnt_reg <= `WOT_PRI_RESET;
    end else if (state_reg == wot_pkg::WOT_IDLE || abort) begin
      // counters track the written periods while stopped
      pre_cnt_reg  <= prescale_reg;
      main_cnt_reg <= primary_period_reg;
    end else if (pre_uflow) begin
      pre_cnt_reg <= prescale_reg;
      if (main_uflow) begin
        if (state_reg == wot_pkg::WOT_WAIT) begin
          main_cnt_reg <= secondary_period_reg;
        end else begin
          main_cnt_reg <= primary_period_reg;
        end
      end else begin
        main_cnt_reg <= main_cnt_reg - 1'b1;
      end
    end else if (tick) begin
      pre_cnt_reg <= pre_cnt_reg - 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // half count-source delay to pulse end and interrupt
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      end_pending_reg <= 1'b0;
      half_cnt_reg    <= 2'h0;
    end else if (state_reg == wot_pkg::WOT_PULSE && main_uflow && !abort) begin
      end_pending_reg <= 1'b1;
      half_cnt_reg    <= 2'h0;
    end else if (end_pending_reg) begin
      // clk/8 ends four clocks after the underflow; the count is ignored for the other sources
      end_pending_reg <= ~end_now;
      half_cnt_reg    <= half_cnt_reg + 2'h1;
    end
  end

  // ----------------------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= end_now;
    end
  end

  // ----------------------------------------------------------------------------
  // pulse output
  // ----------------------------------------------------------------------------
  // a stop before the secondary underflow drops the pulse with no interrupt
  always_comb begin
    pulse_next = pulse_reg;
    if (state_reg == wot_pkg::WOT_WAIT && main_uflow && !abort) begin
      pulse_next = 1'b1;
    end else if (abort || end_now) begin
      pulse_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= pulse_next;
    end
  end

  // ----------------------------------------------------------------------------
  // pulse pin
  // ----------------------------------------------------------------------------
  // the pin is a flop: a change of output level reaches it one clock later
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_reg <= 1'b0;
    end else begin
      pin_reg <= pulse_next ^ output_level_select_i;
    end
  end

  assign pulse_output_pin_o = pin_reg;

  // ----------------------------------------------------------------------------
  // status flag
  // ----------------------------------------------------------------------------

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oneshot_status_flag_o <= 1'b0;
    end else if (state_reg == wot_pkg::WOT_IDLE) begin
      oneshot_status_flag_o <= trigger;
    end else if (abort || (state_reg == wot_pkg::WOT_PULSE && main_uflow)) begin
      oneshot_status_flag_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // read-back
  // ----------------------------------------------------------------------------
  assign prescale_count_o       = pre_cnt_reg;
  assign primary_count_o        = main_cnt_reg;
  assign prescale_reg_o         = prescale_reg;
  assign primary_period_reg_o   = primary_period_reg;
  assign secondary_period_reg_o = secondary_period_reg;
  assign count_enable_o         = count_enable_reg;
  assign irq_o                  = irq_reg;

endmodule : wot_timer

//--- logic/wot_trig_sync.sv
// wot_trig_sync.sv: external trigger pin synchroniser with selectable edge detector
// assumes: pin is asynchronous to clk_i
`timescale 1ns/1ns

module wot_trig_sync (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  input  wire logic falling_i,
  output logic      edge_o
);

  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  // ----------------------------------------------------------------------------
  // two-stage synchroniser and edge history
  // ----------------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end else begin
      meta_reg <= pin_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign edge_o = falling_i ? (prev_reg & ~sync_reg) : (sync_reg & ~prev_reg);

endmodule : wot_trig_sync

//--- verification/tb_top.sv
// tb_top.sv: self-checking bench of the wait one-shot timer
// assumes: package, design, load model and checker compiled before
`timescale 1ns/1ns

module tb_top;
  localparam int W = 8;
  logic               clk_i, rst_n_i, en, fst, sst, ssp, lvl, xsel, xfal, xpin, fire, cuf;
  logic               pwr, mwr, swr, ceo, flag, pin, irq;
  logic [1:0]         cdiv;
  wot_pkg::wot_src_t  src;
  logic [W-1:0]       wd, pcnt, mcnt, preg, mreg, sreg;
  int                 act, irqs, fails, comparisons;

  wot_timer #(.W(W)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .src_sel_i(src),
    .companion_uflow_i(cuf), .count_enable_bit_i(en), .forced_stop_bit_i(fst),
    .oneshot_start_bit_i(sst), .oneshot_stop_bit_i(ssp), .output_level_select_i(lvl),
    .ext_trig_select_i(xsel), .ext_trig_falling_i(xfal), .external_trigger_pin_i(xpin),
    .prescale_wr_i(pwr), .primary_wr_i(mwr), .secondary_wr_i(swr), .wr_data_i(wd),
    .prescale_count_o(pcnt), .primary_count_o(mcnt), .prescale_reg_o(preg),
    .primary_period_reg_o(mreg), .secondary_period_reg_o(sreg), .count_enable_o(ceo),
    .oneshot_status_flag_o(flag), .pulse_output_pin_o(pin), .irq_o(irq));
  wot_trig_load ld (.clk_i(clk_i), .fire_i(fire), .falling_i(xfal), .load_i(pin),
    .lvl_i(lvl), .pin_o(xpin), .active_o(act));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // companion underflow every third cycle
  always @(posedge clk_i) begin
    cdiv <= (cdiv == 2'h2) ? 2'h0 : cdiv + 2'h1;
    cuf <= (cdiv == 2'h2);
    if (irq === 1'b1) irqs <= irqs + 1;
  end

  // ----------------------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic rng(input string what, input int lo, hi, got);
    comparisons++;
    if (got < lo || got > hi) begin
      fails++;
      $display("wrong value %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : rng
  task automatic wr(input logic [2:0] sel, input logic [W-1:0] d);
    @(posedge clk_i);
    wd <= d;
    {swr, mwr, pwr} <= sel;
    @(posedge clk_i);
    {swr, mwr, pwr} <= 3'h0;
  endtask : wr
  // 0 start, 1 stop, 2 forced stop, 3 trigger pin edge
  task automatic pulse_in(input int k);
    @(posedge clk_i);
    case (k)
      0: sst <= 1'b1;
      1: ssp <= 1'b1;
      2: fst <= 1'b1;
      default: fire <= 1'b1;
    endcase
    @(posedge clk_i);
    {sst, ssp, fst, fire} <= 4'h0;
  endtask : pulse_in
  task automatic til(ref logic s, input logic v, output int t);
    t = 0;
    while (s !== v && t < 3000) begin
      @(negedge clk_i);
      t++;
    end
    if (t >= 3000) chk("handshake wait", 16'(v), 16'(s));
  endtask : til
  task automatic shot(input wot_pkg::wot_src_t s, input logic [W-1:0] n, m, p, input int how);
    int d, t, ti, a0, i0;
    d = (s == 2'h0) ? 1 : (s == 2'h1) ? 2 : (s == 2'h2) ? 8 : 3;
    @(posedge clk_i);
    src <= s;
    wr(3'h1, n);
    wr(3'h2, m);
    wr(3'h4, p);
    a0 = act;
    i0 = irqs;
    pulse_in(how);
    @(negedge clk_i);
    chk("idle level", 16'(lvl), 16'(pin));
    til(flag, 1'b1, t);
    til(pin, ~lvl, t);
    rng("wait", d * (n + 1) * (m + 1) - d + 1, d * (n + 1) * (m + 1) + d - 1, t);
    til(flag, 1'b0, t);
    chk("pulse", 16'(d * (n + 1) * (p + 1)), 16'(t));
    til(irq, 1'b1, ti);
    chk("irq delay", 16'((d == 3) ? 3 : (d + 1) / 2), 16'(ti));
    chk("pin at irq", 16'(lvl), 16'(pin));
    chk("load cycles", 16'(t + ti), 16'(act - a0));
    repeat (8) @(negedge clk_i);
    chk("irq count", 16'(i0 + 1), 16'(irqs));
    chk("reload", {m, n}, {mcnt, pcnt});
  endtask : shot
  // 0 forced stop in wait, 1 stop in pulse, 2 enable cleared in wait
  task automatic abort(input int k);
    int t, i0;
    i0 = irqs;
    pulse_in(0);
    @(negedge clk_i);
    if (k == 1) til(pin, ~lvl, t);
    else repeat (5) @(negedge clk_i);
    if (k == 2) begin
      @(posedge clk_i);
      en <= 1'b0;
    end else pulse_in(k == 0 ? 2 : 1);
    repeat (6) @(negedge clk_i);
    chk("abort flag pin", {15'h0000, lvl}, {14'h0000, flag, pin});
    chk("abort irq", 16'(i0), 16'(irqs));
    chk("abort reload", 16'h0014, 16'(mcnt));
    @(posedge clk_i);
    en <= 1'b0;
    @(posedge clk_i);
    en <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask : abort
  task automatic end_of_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : end_of_test

  // ----------------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------------
  initial begin
    {rst_n_i, en, fst, sst, ssp, lvl, xsel, xfal, fire, cuf, pwr, mwr, swr} = '0;
    src = 2'h0;
    cdiv = 2'h0;
    wd = 8'h00;
    {irqs, fails, comparisons} = '0;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    en <= 1'b1;
    @(negedge clk_i);
    chk("reset periods", 16'hFFFF, {preg, mreg});
    chk("reset counts", 16'hFFFF, {sreg, mcnt});
    chk("reset status", 16'hFF00, {pcnt, 6'h00, flag, pin});
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_i);
      lvl <= i[0];
      shot(2'(i), 8'(i), 8'(i + 1), 8'(3 - i), 0);
    end
    shot(2'h0, 8'h00, 8'h00, 8'h00, 0);
    shot(2'h0, 8'h00, 8'h00, 8'h00, 0);
    $display("test sources done");
    @(posedge clk_i);
    en <= 1'b0;
    repeat (3) @(posedge clk_i);
    pulse_in(0);
    @(posedge clk_i);
    en <= 1'b1;
    repeat (3) @(posedge clk_i);
    pulse_in(3);
    repeat (10) @(negedge clk_i);
    chk("refused start", 16'h0001, {14'h0000, flag, ceo});
    $display("test refusal done");
    for (int i = 0; i < 2; i++) begin
      @(posedge clk_i);
      xsel <= 1'b0;
      xfal <= i[0];
      repeat (10) @(posedge clk_i);
      xsel <= 1'b1;
      shot(2'h1, 8'h01, 8'h00, 8'h02, 3);
    end
    @(posedge clk_i);
    xsel <= 1'b0;
    $display("test trigger pin done");
    wr(3'h1, 8'h03);
    wr(3'h2, 8'h14);
    wr(3'h4, 8'h14);
    for (int k = 0; k < 3; k++) abort(k);
    $display("test abort done");
    end_of_test();
  end

  initial begin
    #200000;
    fails++;
    end_of_test();
  end
endmodule : tb_top

//--- verification/wot_timer_sva.sv
// wot_timer_sva.sv: port assertions of the wait one-shot timer
// assumes: bound to wot_timer; one clock, asynchronous active-low reset
`timescale 1ns/1ns

module wot_timer_sva #(
  parameter int W = 8
) (
  input wire logic         clk_i,
  input wire logic         rst_n_i,
  input wire logic         count_enable_bit_i,
  input wire logic         forced_stop_bit_i,
  input wire logic         oneshot_start_bit_i,
  input wire logic         oneshot_stop_bit_i,
  input wire logic         output_level_select_i,
  input wire logic         prescale_wr_i,
  input wire logic         primary_wr_i,
  input wire logic [W-1:0] wr_data_i,
  input wire logic [W-1:0] prescale_count_o,
  input wire logic [W-1:0] primary_count_o,
  input wire logic [W-1:0] prescale_reg_o,
  input wire logic [W-1:0] primary_period_reg_o,
  input wire logic         count_enable_o,
  input wire logic         oneshot_status_flag_o,
  input wire logic         pulse_output_pin_o,
  input wire logic         irq_o
);
  // ----------------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------------
  logic [4:0] idle_cnt_reg;

  // cycles since the status flag was last seen high, saturating
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      idle_cnt_reg <= 5'h1F;
    end else if (oneshot_status_flag_o) begin
      idle_cnt_reg <= 5'h00;
    end else if (idle_cnt_reg != 5'h1F) begin
      idle_cnt_reg <= idle_cnt_reg + 5'h01;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence seq_quiet;
    (!oneshot_status_flag_o && !irq_o && pulse_output_pin_o == $past(output_level_select_i))
    ##1 !irq_o;
  endsequence

  // ----------------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------------
  chk_start_sets_flag: assert property (oneshot_start_bit_i && count_enable_o && count_enable_bit_i
    && !forced_stop_bit_i && !oneshot_stop_bit_i && !oneshot_status_flag_o
    && !$past(oneshot_status_flag_o) |=> oneshot_status_flag_o) else $error("start not taken");
  chk_start_needs_en: assert property (!count_enable_o && !oneshot_status_flag_o
    |=> !oneshot_status_flag_o) else $error("start taken while disabled");
  chk_stop_aborts: assert property (oneshot_stop_bit_i && oneshot_status_flag_o
    |=> seq_quiet) else $error("stop did not end the shot");
  chk_forced_stop: assert property (forced_stop_bit_i |=> seq_quiet
    and !count_enable_o) else $error("forced stop did not stop");
  chk_enable_low: assert property (!count_enable_bit_i |=> ##1 !oneshot_status_flag_o)
    else $error("flag high with enable low");
  chk_irq_at_end: assert property (irq_o
    |-> pulse_output_pin_o == $past(output_level_select_i)
    && $past(pulse_output_pin_o) != $past(output_level_select_i, 2))
    else $error("irq off pulse end");
  chk_irq_single: assert property (irq_o |=> !irq_o [*2]) else $error("irq too long");
  chk_pin_idle: assert property (idle_cnt_reg >= 5'h14
    |-> pulse_output_pin_o == $past(output_level_select_i)) else $error("pin active while idle");
  chk_idle_reload: assert property (!oneshot_status_flag_o && idle_cnt_reg >= 5'h03
    && $stable(primary_period_reg_o) && $stable(prescale_reg_o)
    && $past(primary_period_reg_o, 2) == primary_period_reg_o
    |-> primary_count_o == primary_period_reg_o && prescale_count_o == prescale_reg_o)
    else $error("counters not reloaded");
  chk_write_pre: assert property (prescale_wr_i |=> prescale_reg_o == $past(wr_data_i))
    else $error("prescale write lost");
  chk_write_pri: assert property (primary_wr_i |=> primary_period_reg_o == $past(wr_data_i))
    else $error("primary write lost");
endmodule : wot_timer_sva

bind wot_timer wot_timer_sva #(.W(W)) u_sva (.clk_i, .rst_n_i, .count_enable_bit_i,
  .forced_stop_bit_i, .oneshot_start_bit_i, .oneshot_stop_bit_i, .output_level_select_i,
  .prescale_wr_i, .primary_wr_i, .wr_data_i, .prescale_count_o, .primary_count_o,
  .prescale_reg_o, .primary_period_reg_o, .count_enable_o, .oneshot_status_flag_o,
  .pulse_output_pin_o, .irq_o);

//--- verification/wot_trig_load.sv
// wot_trig_load.sv: external trigger source and pulse output load
// assumes: fire_i is a one-cycle request on clk_i
`timescale 1ns/1ns

module wot_trig_load (
  input  wire logic clk_i,
  input  wire logic fire_i,
  input  wire logic falling_i,
  input  wire logic load_i,
  input  wire logic lvl_i,
  output logic      pin_o,
  output int        active_o
);
  // ----------------------------------------------------------------------------
  // trigger edge and active-level counter
  // ----------------------------------------------------------------------------
  int hold = 0;
  initial active_o = 0;
  // pin rests at the level that makes the chosen edge on leaving it
  assign pin_o = (hold > 0) ? ~falling_i : falling_i;
  always @(posedge clk_i) begin
    hold <= fire_i ? 6 : ((hold > 0) ? hold - 1 : 0);
    if ((load_i ^ lvl_i) === 1'b1) active_o <= active_o + 1;
  end
endmodule : wot_trig_load
